// ### src/bridge_status_pkg.sv
package bridge_status_pkg;

  // ==========================================================
  // geometry
  localparam int                BRIDGES          = 3;
  localparam int                PWM_INPUTS       = 6;
  localparam int                WORD_W           = 16;
  localparam int                ADDR_W           = 7;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] ADDR_GENERAL     = 7'h50;
  localparam logic [ADDR_W-1:0] ADDR_DELAY_REG   = 7'h51;

  // ==========================================================
  // general status field positions
  localparam int                GEN_PWM_LSB      = 0;
  localparam int                GEN_LEVEL_LSB    = 6;

  // ==========================================================
  // delay-regulation status field positions
  localparam int                DLY_REG_LSB      = 0;
  localparam int                DLY_PCHG_LSB     = 4;
  localparam int                DLY_PDCHG_LSB    = 8;

  // ==========================================================
  // reset values and masks
  localparam logic [15:0]       GENERAL_RESET    = 16'h0000;
  localparam logic [15:0]       DELAY_RESET      = 16'h0000;
  localparam logic [15:0]       RESTART_KEEP     = 16'h00c1;
  localparam logic [15:0]       READ_UNMAPPED    = 16'h0000;

  // ==========================================================
  // configuration codes
  localparam logic [1:0]        MODE_ACTIVE      = 2'h3;
  localparam logic [1:0]        AGC_ADAPT_LO     = 2'h2;
  localparam logic [1:0]        AGC_ADAPT_HI     = 2'h3;

  // ==========================================================
  // types
  typedef struct packed {
    logic [PWM_INPUTS-1:0] pwm;
    logic [BRIDGES-1:0]    level_cmp;
    logic [BRIDGES-1:0]    pchg_clamp;
    logic [BRIDGES-1:0]    pdchg_clamp;
    logic [BRIDGES-1:0]    delay_reg;
  } raw_pins_t;

  typedef struct packed {
    raw_pins_t stage1;
    raw_pins_t stage2;
  } sync_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] general_bridge_status;
    logic [WORD_W-1:0] delay_regulation_status;
    logic [WORD_W-1:0] rdata;
    logic              rd_valid;
    logic              rd_err;
    logic              wr_ignored;
  } status_state_t;

endpackage : bridge_status_pkg

// ### src/pin_sync_if.sv
`timescale 1ns/1ns
interface pin_sync_if;
  import bridge_status_pkg::*;

  raw_pins_t raw;
  raw_pins_t synced;

  modport source (output raw, input synced);
  modport sync   (input raw, output synced);

endinterface : pin_sync_if

// ### src/pin_synchronizer.sv
`timescale 1ns/1ns
module pin_synchronizer
  import bridge_status_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  pin_sync_if.sync  pins
);

  // ==========================================================
  // two-stage capture of every asynchronous level
  sync_state_t s;
  sync_state_t next_s;

  // stage1 feeds stage2 only; metastability settles there
  always_comb begin
    next_s        = s;
    next_s.stage1 = pins.raw;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins.synced = s.stage2;

endmodule : pin_synchronizer

// ### src/bridge_driver_status_regs.sv
`timescale 1ns/1ns
// How it works
// - general status bits 15:9 always read zero
// - output level bits 8..6 follow comparator only with mode 11 and pump on
// - level bit is 1 when supply minus output within threshold, else 0
// - level bit reads 0 when pump off or mode not 11
// - bits 5..0 show sampled levels of pwm inputs six to one
// - bit 0 shows the shared pwm one / crc select pin
// - power-on or soft reset clears the general status word
// - restart clears general status except bits 7, 6 and 0
// - predischarge bits 10..8 read 0 when current is clamped
// - predischarge bit reads 1 when current is between the clamp limits
// - precharge bits 6..4 read 0 when current is clamped
// - precharge bit reads 1 when current is between the clamp limits
// - delay word bits 15:11, 7 and 3 are reserved
// - charge status bits read 1 unless pwm on, driven, adaptive gate 10/11
// - delay word bits 2..0 show per-bridge delay regulation active
module bridge_driver_status_regs
  import bridge_status_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           soft_reset,
  input  wire logic                           restart_mode,
  input  wire logic                           charge_pump_enable,
  input  wire logic [BRIDGES-1:0][1:0]        bridge_mode_field,
  input  wire logic [1:0]                     adaptive_gate_setting,
  input  wire logic [BRIDGES-1:0]             bridge_pwm_enable,
  input  wire logic [BRIDGES-1:0]             bridge_high_z,
  input  wire logic [PWM_INPUTS-1:0]          pwm_in_level,
  input  wire logic [BRIDGES-1:0]             bridge_output_node_high,
  input  wire logic [BRIDGES-1:0]             precharge_at_clamp,
  input  wire logic [BRIDGES-1:0]             predischarge_at_clamp,
  input  wire logic [BRIDGES-1:0]             delay_in_regulation,
  input  wire logic [ADDR_W-1:0]              reg_addr,
  input  wire logic                           reg_rd,
  input  wire logic                           reg_wr,
  input  wire logic [WORD_W-1:0]              reg_wdata,
  output logic      [WORD_W-1:0]              reg_rdata,
  output logic                                reg_rd_valid,
  output logic                                reg_rd_err,
  output logic                                reg_wr_ignored
);

  // ==========================================================
  // pin synchronisation
  pin_sync_if pins ();

  assign pins.raw.pwm         = pwm_in_level;
  assign pins.raw.level_cmp   = bridge_output_node_high;
  assign pins.raw.pchg_clamp  = precharge_at_clamp;
  assign pins.raw.pdchg_clamp = predischarge_at_clamp;
  assign pins.raw.delay_reg   = delay_in_regulation;

  pin_synchronizer u_sync (
    .clk  (clk),
    .rst  (rst),
    .pins (pins.sync)
  );

  // ==========================================================
  // per-bridge status evaluation
  logic [BRIDGES-1:0] bridge_output_level;
  logic [BRIDGES-1:0] adaptive_active;
  logic [BRIDGES-1:0] precharge_clamp_flag;
  logic [BRIDGES-1:0] predischarge_clamp_flag;
  logic [BRIDGES-1:0] delay_regulating_flag;
  logic               adaptive_code;

  // only the two adaptive codes let the clamp sensors matter
  assign adaptive_code = (adaptive_gate_setting == AGC_ADAPT_LO) ||
                         (adaptive_gate_setting == AGC_ADAPT_HI);

  genvar b;
  generate
    for (b = 0; b < BRIDGES; b++) begin : g_bridge
      // comparator high means supply minus node is within threshold
      assign bridge_output_level[b] = charge_pump_enable &&
                                      (bridge_mode_field[b] == MODE_ACTIVE) &&
                                      pins.synced.level_cmp[b];

      assign adaptive_active[b] = bridge_pwm_enable[b] &&
                                  !bridge_high_z[b] &&
                                  adaptive_code;

      // clamped current reads 0, anything in between reads 1
      assign precharge_clamp_flag[b] = adaptive_active[b] ?
                                       !pins.synced.pchg_clamp[b] :
                                       1'b1;

      assign predischarge_clamp_flag[b] = adaptive_active[b] ?
                                          !pins.synced.pdchg_clamp[b] :
                                          1'b1;

      assign delay_regulating_flag[b] = pins.synced.delay_reg[b];
    end
  endgenerate

  // ==========================================================
  // status words and register read port
  status_state_t s;
  status_state_t next_s;

  always_comb begin
    logic [WORD_W-1:0] general_word;
    logic [WORD_W-1:0] delay_word;
    general_word = '0;
    delay_word   = '0;
    next_s       = s;

    general_word[GEN_PWM_LSB +: PWM_INPUTS] = pins.synced.pwm;
    general_word[GEN_LEVEL_LSB +: BRIDGES]  = bridge_output_level;

    delay_word[DLY_REG_LSB +: BRIDGES]   = delay_regulating_flag;
    delay_word[DLY_PCHG_LSB +: BRIDGES]  = precharge_clamp_flag;
    delay_word[DLY_PDCHG_LSB +: BRIDGES] = predischarge_clamp_flag;

    // soft reset outranks restart: it wipes the kept bits as well
    if (soft_reset) begin
      general_word = GENERAL_RESET;
      delay_word   = DELAY_RESET;
    end else if (restart_mode) begin
      general_word = general_word & RESTART_KEEP;
      delay_word   = delay_word & RESTART_KEEP;
    end

    next_s.general_bridge_status   = general_word;
    next_s.delay_regulation_status = delay_word;

    next_s.rd_valid   = 1'b0;
    next_s.rd_err     = 1'b0;
    // writes are acknowledged as ignored and never reach the words
    next_s.wr_ignored = reg_wr;

    if (reg_rd) begin
      next_s.rd_valid = 1'b1;
      unique case (reg_addr)
        ADDR_GENERAL: begin
          next_s.rdata = s.general_bridge_status;
        end
        ADDR_DELAY_REG: begin
          next_s.rdata = s.delay_regulation_status;
        end
        default: begin
          next_s.rdata  = READ_UNMAPPED;
          next_s.rd_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.general_bridge_status   <= GENERAL_RESET;
      s.delay_regulation_status <= DELAY_RESET;
      s.rdata                   <= '0;
      s.rd_valid                <= 1'b0;
      s.rd_err                  <= 1'b0;
      s.wr_ignored              <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // write data is deliberately unused; words stay read only
  logic unused_wdata;
  assign unused_wdata = ^reg_wdata;

  assign reg_rdata      = s.rdata;
  assign reg_rd_valid   = s.rd_valid;
  assign reg_rd_err     = s.rd_err;
  assign reg_wr_ignored = s.wr_ignored;

endmodule : bridge_driver_status_regs

// ### testbench/bridge_status_monitor.sv
`timescale 1ns/1ns
// ==========
// port checks
module bridge_status_monitor
  import bridge_status_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              soft_reset,
  input wire logic              restart_mode,
  input wire logic              charge_pump_enable,
  input wire logic [1:0]        adaptive_gate_setting,
  input wire logic [5:0]        pwm_in_level,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic [WORD_W-1:0] reg_rdata,
  input wire logic              reg_wr_ignored
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // reset and restart mask both words, so level checks need them quiet
  wire quiet = !soft_reset && !restart_mode;
  sequence rd_gen; reg_rd && reg_addr == ADDR_GENERAL; endsequence
  sequence rd_dly; reg_rd && reg_addr == ADDR_DELAY_REG; endsequence

  gen_rsvd_a: assert property (rd_gen |=> reg_rdata[15:9] == 7'h00)
    else $error("general reserved bits set");
  dly_rsvd_a: assert property (
    rd_dly |=> reg_rdata[15:11] == 5'h00 && !reg_rdata[7] && !reg_rdata[3])
    else $error("delay reserved bits set");
  pump_off_a: assert property (
    (!charge_pump_enable)[*2] ##0 rd_gen |=> reg_rdata[8:6] == 3'h0)
    else $error("level bits set with pump off");
  pwm_level_a: assert property (
    ($stable(pwm_in_level) && quiet)[*6] ##0 rd_gen |=> reg_rdata[5:0] == $past(pwm_in_level))
    else $error("pwm bits wrong");
  agc_plain_a: assert property (
    (!adaptive_gate_setting[1] && quiet)[*3] ##0 rd_dly
    |=> reg_rdata[10:8] == 3'h7 && reg_rdata[6:4] == 3'h7)
    else $error("charge bits not 1");
  restart_a: assert property (
    restart_mode[*2] ##0 rd_gen |=> (reg_rdata & 16'hff3e) == 16'h0000)
    else $error("restart mask wrong");
  soft_clr_a: assert property (soft_reset[*2] ##0 reg_rd |=> reg_rdata == 16'h0000)
    else $error("soft reset not clear");
  wr_ack_a: assert property (reg_wr |=> reg_wr_ignored)
    else $error("write not refused");
endmodule : bridge_status_monitor

bind bridge_driver_status_regs bridge_status_monitor i_bridge_status_monitor (
  .clk(clk), .rst(rst), .soft_reset(soft_reset), .restart_mode(restart_mode),
  .charge_pump_enable(charge_pump_enable), .adaptive_gate_setting(adaptive_gate_setting),
  .pwm_in_level(pwm_in_level), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .reg_wr_ignored(reg_wr_ignored));

// ### testbench/host_model.sv
`timescale 1ns/1ns
// ==========
// host side of the register port
module host_model
  import bridge_status_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic                   reg_rd,
  output logic                   reg_wr,
  output logic      [WORD_W-1:0] reg_wdata,
  input  wire logic [WORD_W-1:0] reg_rdata,
  input  wire logic              reg_rd_valid,
  input  wire logic              reg_rd_err,
  input  wire logic              reg_wr_ignored
);
  initial begin
    reg_addr = '0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = '0;
  end
  // one request per call and a gap edge after it, so strobes never stack
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                      output logic [WORD_W-1:0] q, output logic ack, output logic err);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_rd = !wr;
    reg_wr = wr;
    @(posedge clk);
    #1;
    // valid, err and ignored stand only in the cycle after the taking edge
    q = reg_rdata;
    ack = wr ? reg_wr_ignored : reg_rd_valid;
    err = reg_rd_err;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : xfer
endmodule : host_model

// ### testbench/tb_bridge_driver_status_regs.sv
`timescale 1ns/1ns
// ==========
// bench
module tb_bridge_driver_status_regs
  import bridge_status_pkg::*;
;
  logic              clk = 1'b0, rst = 1'b1, soft_reset = 1'b0, restart_mode = 1'b0;
  logic              charge_pump_enable = 1'b0;
  logic [2:0][1:0]   bridge_mode_field = '0;
  logic [1:0]        adaptive_gate_setting = '0;
  logic [2:0]        bridge_pwm_enable = '0, bridge_high_z = '0, bridge_output_node_high = '0;
  logic [2:0]        precharge_at_clamp = '0, predischarge_at_clamp = '0;
  logic [2:0]        delay_in_regulation = '0;
  logic [5:0]        pwm_in_level = '0;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_rd, reg_wr, reg_rd_valid, reg_rd_err, reg_wr_ignored, ack, err;
  logic [WORD_W-1:0] reg_wdata, reg_rdata, got;
  int                num_errors = 0, checks = 0, cycles = 0;

  bridge_driver_status_regs i_bridge_driver_status_regs (.*);
  host_model i_host_model (.*);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, seen);
    end
  endtask : chk

  // pins pass two sync stages and a register, so wait before reading
  task automatic rd(input logic [ADDR_W-1:0] a);
    repeat (5) @(posedge clk);
    i_host_model.xfer(1'b0, a, 16'h0000, got, ack, err);
    chk("rd valid", 16'h0001, {15'h0000, ack});
  endtask : rd

  task automatic t_pwm();
    for (int i = 0; i < 6; i++) begin
      pwm_in_level = 6'h01 << i;
      rd(ADDR_GENERAL);
      chk("general", {10'h000, 6'h01 << i}, got);
    end
  endtask : t_pwm

  task automatic t_level();
    pwm_in_level = '0;
    charge_pump_enable = 1'b1;
    bridge_mode_field = {2'b11, 2'b10, 2'b11};
    bridge_output_node_high = 3'b111;
    rd(ADDR_GENERAL);
    chk("level", 16'h0140, got);
    bridge_output_node_high = 3'b110;
    rd(ADDR_GENERAL);
    chk("level", 16'h0100, got);
    charge_pump_enable = 1'b0;
    rd(ADDR_GENERAL);
    chk("level", 16'h0000, got);
  endtask : t_level

  task automatic t_delay();
    bridge_pwm_enable = 3'b101;
    bridge_high_z = 3'b100;
    precharge_at_clamp = 3'b011;
    predischarge_at_clamp = 3'b100;
    delay_in_regulation = 3'b101;
    for (int a = 0; a < 4; a++) begin
      adaptive_gate_setting = a[1:0];
      rd(ADDR_DELAY_REG);
      chk("delay", a[1] ? 16'h0765 : 16'h0775, got);
    end
    i_host_model.xfer(1'b1, ADDR_DELAY_REG, 16'hffff, got, ack, err);
    chk("refused", 16'h0001, {15'h0000, ack});
    rd(ADDR_DELAY_REG);
    chk("delay", 16'h0765, got);
  endtask : t_delay

  task automatic t_reset();
    // mid-run power-on reset must clear the read port at once
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk("por", 16'h0000, reg_rdata);
    rst = 1'b0;
    pwm_in_level = 6'h3f;
    charge_pump_enable = 1'b1;
    bridge_mode_field = '1;
    bridge_output_node_high = 3'b111;
    restart_mode = 1'b1;
    rd(ADDR_GENERAL);
    chk("restart", 16'h00c1, got);
    soft_reset = 1'b1;
    rd(ADDR_GENERAL);
    chk("soft", 16'h0000, got);
    soft_reset = 1'b0;
    restart_mode = 1'b0;
    rd(7'h52);
    chk("unmapped", 16'h8000, {err, got[14:0]});
  endtask : t_reset

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_pwm();
    t_level();
    t_delay();
    t_reset();
    give_verdict();
  end
endmodule : tb_bridge_driver_status_regs
